// ===== src/pbridge_consts.svh
// constants for the peripheral bus decode bridge
`ifndef PBRIDGE_CONSTS_SVH
`define PBRIDGE_CONSTS_SVH
`define SER_BASE          32'h8000_0000
`define PIN_CTRL_BASE     32'h9006_0000
`define DISP_BASE         32'hb010_0000
`define REGION_MASK       32'hffff_0000
`define SER_FIELD_MASK    32'hfff8_0000
`define IRQ_DISP_BIT      5'h0c
`define IRQ_FIRST_SER     5'h0d
`define BURST_4_WORDS     4'h4
`define BURST_8_BYTES     4'h8
`define BURST_4_BYTES     4'h4
`define TIMEOUT_CYCLES    8'hff
`endif

// ===== src/pbridge_pkg.sv
// types for the peripheral bus decode bridge
package pbridge_pkg;
    typedef enum logic [1:0] {
        width_8,
        width_16,
        width_32
    } reg_width_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } sys_req_t;

    typedef struct packed {
        logic        ready;
        logic        error;
        logic [31:0] rdata;
    } sys_rsp_t;

    typedef enum logic [2:0] {
        st_idle,
        st_strobe,
        st_release,
        st_done
    } hs_state_t;
endpackage

// ===== src/unit_decode.sv
// address decode of one word access onto the peripheral units
`timescale 1ns/1ps
`default_nettype none
`include "pbridge_consts.svh"
module unit_decode
    import pbridge_pkg::*;
(
    input  wire logic [31:0] i_addr,
    output logic      [8:0]  o_sel,
    output reg_width_t       o_width,
    output logic      [3:0]  o_burst,
    output logic             o_dma_ok,
    output logic             o_hit
);
    logic [2:0] eng;
    assign eng = i_addr[18:16];

    always_comb begin
        o_sel    = 9'h000;
        o_width  = width_8;
        o_burst  = 4'h0;
        o_dma_ok = 1'b0;
        o_hit    = 1'b0;
        if ((i_addr & `SER_FIELD_MASK) == `SER_BASE) begin
            o_sel[eng] = 1'b1;
            o_hit      = 1'b1;
            o_dma_ok   = 1'b1;
            if (eng == 3'h6 || eng == 3'h7) begin
                o_width = width_16;
            end else begin
                o_width = width_8;
            end
            if (eng == 3'h0 || eng == 3'h4 || eng == 3'h6 || eng == 3'h7) begin
                o_burst = `BURST_8_BYTES;
            end else begin
                o_burst = `BURST_4_BYTES;
            end
        end else if ((i_addr & `REGION_MASK) == `PIN_CTRL_BASE) begin
            o_sel[8] = 1'b1;
            o_hit    = 1'b1;
            o_width  = width_32;
            o_dma_ok = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== src/peripheral_bus_decode_bridge.sv
// bridge from the synchronous system bus to the handshake peripheral bus
// Functional notes
// - bridge system bus to peripheral bus, decode
// - peripheral side uses request/acknowledge handshake
// - word accesses only, no byte lanes
// - register widths 8, 16 or 32 bits
// - narrow registers sit in low bits
// - fixed DMA burst length per engine
// - each unit owns one 64 KB region
// - engines at 8000_0000 up, pins, display
// - engines have separate selects; irqs separate except engines 3 and 4 share bit 16
// - ports 1, 2, 4 hold two engines
// - pin controller never requests DMA
// - 32-bit pending shows unmasked unit interrupts
// - pending bits 12 to 19 per unit
// - paired engines have separate interrupt bits, except engines 3 and 4 sharing bit 16
// - display sits on system bus, own DMA
`timescale 1ns/1ps
`default_nettype none
`include "pbridge_consts.svh"
module peripheral_bus_decode_bridge
    import pbridge_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rstn,
    input  wire sys_req_t    i_cpu_req,
    output sys_rsp_t         o_cpu_rsp,
    input  wire sys_req_t    i_dma_req,
    output sys_rsp_t         o_dma_rsp,
    output logic [3:0]       o_dma_burst,
    output logic [8:0]       o_per_sel,
    output logic             o_per_write,
    output logic [15:0]      o_per_offset,
    output logic [31:0]      o_per_wdata,
    output logic             o_per_strobe,
    input  wire logic        i_per_ack,
    input  wire logic [31:0] i_per_rdata,
    input  wire logic [7:0]  i_unit_irq,
    input  wire logic        i_disp_irq,
    input  wire logic [31:0] i_irq_mask,
    output logic [31:0]      o_irq_pending
);
    // two-flop synchroniser for the asynchronous acknowledge
    logic ack_meta_ff;
    logic ack_sync_ff;
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ack_meta_ff <= 1'b0;
            ack_sync_ff <= 1'b0;
        end else begin
            ack_meta_ff <= i_per_ack;
            ack_sync_ff <= ack_meta_ff;
        end
    end

    // source synchronise the pending inputs too
    logic [8:0] irq_meta_ff;
    logic [8:0] irq_sync_ff;
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_meta_ff <= 9'h000;
            irq_sync_ff <= 9'h000;
        end else begin
            irq_meta_ff <= {i_unit_irq, i_disp_irq};
            irq_sync_ff <= irq_meta_ff;
        end
    end

    // one bit per engine except engines 3 and 4 sharing bit 16, engines 1/2 and 6/7 kept apart
    function automatic logic [31:0] map_pending(input logic [8:0] src);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[`IRQ_DISP_BIT] = src[0];
        v[13] = src[1];
        v[14] = src[3];
        v[15] = src[2];
        v[16] = src[4] | src[5];
        v[17] = src[6];
        v[18] = src[7];
        v[19] = src[8];
        return v;
    endfunction

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_irq_pending <= 32'h0000_0000;
        end else begin
            o_irq_pending <= map_pending(irq_sync_ff) & ~i_irq_mask;
        end
    end

    // narrow registers right justified, upper bits forced to zero
    function automatic logic [31:0] justify(input logic [31:0] d, input reg_width_t w);
        logic [31:0] r;
        r = d;
        if (w == width_8) begin
            r = {24'h00_0000, d[7:0]};
        end else if (w == width_16) begin
            r = {16'h0000, d[15:0]};
        end
        return r;
    endfunction

    // arbitration: cpu first, dma next
    hs_state_t   state_ff;
    logic        owner_dma_ff;
    sys_req_t    cur_ff;
    sys_req_t    pick;
    logic        pick_dma;
    logic [8:0]  dec_sel;
    reg_width_t  dec_width;
    reg_width_t  width_ff;
    logic [3:0]  dec_burst;
    logic        dec_dma_ok;
    logic        dec_hit;
    // cycles spent waiting for the acknowledge
    logic [7:0]  wait_ff;

    // dma only wins while the cpu is quiet
    always_comb begin
        pick_dma = !i_cpu_req.valid && i_dma_req.valid;
        pick     = pick_dma ? i_dma_req : i_cpu_req;
    end

    unit_decode u_decode (
        .i_addr   (pick.addr),
        .o_sel    (dec_sel),
        .o_width  (dec_width),
        .o_burst  (dec_burst),
        .o_dma_ok (dec_dma_ok),
        .o_hit    (dec_hit)
    );

    logic refuse;
    // display region and unmapped addresses never reach peripheral bus
    assign refuse = !dec_hit || (pick_dma && !dec_dma_ok);

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_ff     <= st_idle;
            owner_dma_ff <= 1'b0;
            cur_ff       <= '0;
            width_ff     <= width_8;
            o_per_sel    <= 9'h000;
            o_per_write  <= 1'b0;
            o_per_offset <= 16'h0000;
            o_per_wdata  <= 32'h0000_0000;
            o_per_strobe <= 1'b0;
            o_dma_burst  <= 4'h0;
            o_cpu_rsp    <= '0;
            o_dma_rsp    <= '0;
            wait_ff      <= 8'h00;
        end else begin
            o_cpu_rsp.ready <= 1'b0;
            o_dma_rsp.ready <= 1'b0;
            case (state_ff)
                st_idle: begin
                    if (pick.valid && refuse) begin
                        if (pick_dma) begin
                            o_dma_rsp <= '{ready: 1'b1, error: 1'b1, rdata: 32'h0000_0000};
                        end else begin
                            o_cpu_rsp <= '{ready: 1'b1, error: 1'b1, rdata: 32'h0000_0000};
                        end
                        state_ff <= st_done;
                    end else if (pick.valid && !ack_sync_ff) begin
                        owner_dma_ff <= pick_dma;
                        cur_ff       <= pick;
                        width_ff     <= dec_width;
                        o_per_sel    <= dec_sel;
                        o_per_write  <= pick.write;
                        o_per_offset <= pick.addr[15:0];
                        // write data justified to the register width, upper bits zero, no byte lanes
                        o_per_wdata  <= justify(pick.wdata, dec_width);
                        o_dma_burst  <= pick_dma ? dec_burst : 4'h0;
                        o_per_strobe <= 1'b1;
                        wait_ff      <= 8'h00;
                        state_ff     <= st_strobe;
                    end
                end
                st_strobe: begin
                    wait_ff <= wait_ff + 8'h01;
                    if (ack_sync_ff || wait_ff == `TIMEOUT_CYCLES) begin
                        o_per_strobe <= 1'b0;
                        // writes and timed-out cycles answer with zero data
                        if (owner_dma_ff) begin
                            o_dma_rsp.rdata <= (cur_ff.write || !ack_sync_ff) ? 32'h0000_0000
                                                                              : justify(i_per_rdata, width_ff);
                            o_dma_rsp.error <= !ack_sync_ff;
                        end else begin
                            o_cpu_rsp.rdata <= (cur_ff.write || !ack_sync_ff) ? 32'h0000_0000
                                                                              : justify(i_per_rdata, width_ff);
                            o_cpu_rsp.error <= !ack_sync_ff;
                        end
                        state_ff <= st_release;
                    end
                end
                st_release: begin
                    // wait for acknowledge to drop before answering
                    if (!ack_sync_ff) begin
                        o_per_sel <= 9'h000;
                        if (owner_dma_ff) begin
                            o_dma_rsp.ready <= 1'b1;
                        end else begin
                            o_cpu_rsp.ready <= 1'b1;
                        end
                        state_ff <= st_done;
                    end
                end
                st_done: begin
                    // one idle cycle so the master can drop valid
                    state_ff <= st_idle;
                end
                default: begin
                    state_ff <= st_idle;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== testbench/pbridge_assertions.sv
// property checker for the peripheral bus decode bridge ports
`timescale 1ns/1ps
`default_nettype none
module pbridge_chk
    import pbridge_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rstn,
    input  wire sys_rsp_t    o_cpu_rsp,
    input  wire logic [3:0]  o_dma_burst,
    input  wire logic [8:0]  o_per_sel,
    input  wire logic        o_per_write,
    input  wire logic [15:0] o_per_offset,
    input  wire logic [31:0] o_per_wdata,
    input  wire logic        o_per_strobe,
    input  wire logic        i_per_ack,
    input  wire logic [31:0] o_irq_pending
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    property p_pend; o_irq_pending[31:20] == 0 && o_irq_pending[11:0] == 0; endproperty
    a_pend: assert property (p_pend) else $error("pending bit outside unit range");
    property p_pin; o_per_sel[8] |-> o_dma_burst == 4'h0; endproperty
    a_pin: assert property (p_pin) else $error("dma cycle to pin controller");
    property p_hot; $onehot0(o_per_sel); endproperty
    a_hot: assert property (p_hot) else $error("more than one unit selected");
    property p_stb; o_per_strobe |-> o_per_sel != 0; endproperty
    a_stb: assert property (p_stb) else $error("strobe without select");
    property p_hold; o_per_sel != 0 && $past(o_per_sel) != 0 |-> $stable({o_per_sel, o_per_write, o_per_offset, o_per_wdata}); endproperty
    a_hold: assert property (p_hold) else $error("peripheral cycle changed midway");
    property p_ack; $rose(i_per_ack) && o_per_strobe |-> ##[1:4] !o_per_strobe; endproperty
    a_ack: assert property (p_ack) else $error("strobe kept after acknowledge");
    property p_rdy; o_cpu_rsp.ready |=> !o_cpu_rsp.ready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready longer than one cycle");
    property p_w8; o_per_write && |o_per_sel[5:0] |-> o_per_wdata[31:8] == 0; endproperty
    a_w8: assert property (p_w8) else $error("byte unit write has upper bits");
    property p_w16; o_per_write && |o_per_sel[7:6] |-> o_per_wdata[31:16] == 0; endproperty
    a_w16: assert property (p_w16) else $error("half unit write has upper bits");
    property p_bst; o_dma_burst inside {4'h0, 4'h4, 4'h8}; endproperty
    a_bst: assert property (p_bst) else $error("illegal burst length");
    property p_err; o_cpu_rsp.ready && o_cpu_rsp.error |-> o_cpu_rsp.rdata == 0; endproperty
    a_err: assert property (p_err) else $error("refused read returned data");
    c_ok: cover property (o_cpu_rsp.ready && !o_cpu_rsp.error);
    c_b8: cover property (o_per_strobe && o_dma_burst == 4'h8);
    c_irq: cover property (o_irq_pending != 0);
endmodule
bind peripheral_bus_decode_bridge pbridge_chk i_pbridge_chk (.i_core_clk, .i_rstn, .o_cpu_rsp, .o_dma_burst,
    .o_per_sel, .o_per_write, .o_per_offset, .o_per_wdata, .o_per_strobe, .i_per_ack, .o_irq_pending);
`default_nettype wire

// ===== testbench/per_unit_model.sv
// handshake responder standing for the nine peripheral units
`timescale 1ns/1ps
`default_nettype none
module per_unit_model (
    input  wire logic        i_core_clk,
    input  wire logic        i_rstn,
    input  wire logic [8:0]  i_sel,
    input  wire logic        i_write,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_strobe,
    input  wire logic [7:0]  i_delay,
    output logic             o_ack,
    output logic [31:0]      o_rdata
);
    logic [31:0] regs [9];
    int          cnt;
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_ack <= 1'b0;
            o_rdata <= 32'h5a5a_a5a5;
            cnt = 0;
            foreach (regs[u]) regs[u] = 32'h0;
        end else if (i_strobe && !o_ack) begin
            if (cnt >= i_delay) begin
                cnt = 0;
                o_ack <= 1'b1;
                foreach (regs[u]) if (i_sel[u]) begin
                    if (i_write) regs[u] = i_wdata;
                    else o_rdata <= regs[u];
                end
            end else cnt++;
        end else if (!i_strobe && o_ack) begin
            o_ack <= 1'b0;
            o_rdata <= ~o_rdata;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the peripheral bus decode bridge
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", nm, e, s); end end
module tb_top;
    import pbridge_pkg::*;
    typedef struct packed {logic err; logic rdc; logic [31:0] rd; logic [8:0] sel; logic [3:0] bst;} note_t;
    logic        clk, rstn, per_ack, disp_irq, stb_q;
    sys_req_t    cpu_req, dma_req, q;
    sys_rsp_t    cpu_rsp, dma_rsp, r;
    logic [3:0]  dma_burst;
    logic [8:0]  per_sel;
    logic [15:0] per_offset;
    logic [31:0] per_wdata, per_rdata, irq_mask, irq_pend, seed, a, d, m, e;
    logic [7:0]  unit_irq, dly;
    logic        per_write, per_strobe;
    note_t       nq [$];
    note_t       n;
    int          err_total, checks_done, u;
    logic [3:0]  bst_tbl [8] = '{4'h8, 4'h4, 4'h4, 4'h4, 4'h8, 4'h4, 4'h8, 4'h8};
    int          irq_tbl [8] = '{13, 15, 14, 16, 16, 17, 18, 19};
    peripheral_bus_decode_bridge i_peripheral_bus_decode_bridge (.i_core_clk(clk), .i_rstn(rstn),
        .i_cpu_req(cpu_req), .o_cpu_rsp(cpu_rsp), .i_dma_req(dma_req), .o_dma_rsp(dma_rsp),
        .o_dma_burst(dma_burst), .o_per_sel(per_sel), .o_per_write(per_write), .o_per_offset(per_offset),
        .o_per_wdata(per_wdata), .o_per_strobe(per_strobe), .i_per_ack(per_ack), .i_per_rdata(per_rdata),
        .i_unit_irq(unit_irq), .i_disp_irq(disp_irq), .i_irq_mask(irq_mask), .o_irq_pending(irq_pend));
    per_unit_model i_per_unit_model (.i_core_clk(clk), .i_rstn(rstn), .i_sel(per_sel), .i_write(per_write),
        .i_wdata(per_wdata), .i_strobe(per_strobe), .i_delay(dly), .o_ack(per_ack), .o_rdata(per_rdata));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic results();
        if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic acc(input logic dm, input logic wr, input logic [31:0] ad, dd, input note_t nn);
        int k;
        nq.push_back(nn);
        @(posedge clk);
        #2;
        if (dm) dma_req = '{1'b1, wr, ad, dd};
        else cpu_req = '{1'b1, wr, ad, dd};
        for (k = 0; k < 600; k++) begin
            @(posedge clk);
            if ((dm ? dma_rsp.ready : cpu_rsp.ready) === 1'b1) break;
        end
        #2 cpu_req.valid = 1'b0;
        dma_req.valid = 1'b0;
        if (k == 600) begin err_total++; results(); end
    endtask
    task automatic wait_pend(input logic [31:0] ex);
        for (int k = 0; k < 10 && irq_pend !== ex; k++) @(posedge clk);
        `CHK("pending", ex, irq_pend)
    endtask
    // expectation queue consumer
    always @(posedge clk) begin
        if (per_strobe && !stb_q && nq.size() > 0) begin
            q = cpu_req.valid ? cpu_req : dma_req;
            `CHK("select", nq[0].sel, per_sel)
            `CHK("burst", nq[0].bst, dma_burst)
            `CHK("offset", q.addr[15:0], per_offset)
            `CHK("write", q.write, per_write)
            if (q.write) `CHK("wdata", q.wdata & m, per_wdata)
        end
        stb_q = per_strobe;
        if ((cpu_rsp.ready === 1'b1 || dma_rsp.ready === 1'b1) && nq.size() > 0) begin
            n = nq.pop_front();
            r = cpu_rsp.ready ? cpu_rsp : dma_rsp;
            `CHK("error", n.err, r.error)
            if (n.rdc) `CHK("rdata", n.rd, r.rdata)
        end
    end
    initial begin
        {cpu_req, dma_req, unit_irq, disp_irq, irq_mask, dly, rstn, stb_q} = '0;
        seed = 32'h4e7cee12;
        repeat (8) @(posedge clk);
        #2 rstn = 1'b1;
        for (u = 0; u < 9; u++) begin
            dly = 8'(u * 3);
            a = (u < 8 ? 32'h8000_0000 + (u << 16) : 32'h9006_0000) | (xs() & 32'hfffc);
            d = xs();
            m = u < 6 ? 32'hff : u < 8 ? 32'hffff : 32'hffff_ffff;
            acc(1'b0, 1'b1, a, d, note_t'{1'b0, 1'b0, 32'h0, 9'h1 << u, 4'h0});
            acc(1'b0, 1'b0, a, 32'h0, note_t'{1'b0, 1'b1, d & m, 9'h1 << u, 4'h0});
            if (u < 8) acc(1'b1, 1'b0, a, 32'h0, note_t'{1'b0, 1'b1, d & m, 9'h1 << u, bst_tbl[u]});
            else acc(1'b1, 1'b0, a, 32'h0, note_t'{1'b1, 1'b1, 32'h0, 9'h0, 4'h0});
        end
        foreach (irq_tbl[k]) begin
            a = k % 3 == 0 ? 32'hb010_0000 : k % 3 == 1 ? 32'h8008_0000 : 32'h9005_fffc;
            acc(1'(k), 1'(k >> 1), a, xs(), note_t'{1'b1, 1'b1, 32'h0, 9'h0, 4'h0});
        end
        @(posedge clk);
        for (u = 0; u < 9; u++) begin
            e = u < 8 ? 32'h1 << irq_tbl[u] : 32'h1000;
            #2 unit_irq = u < 8 ? 8'h1 << u : 8'h0;
            disp_irq = u == 8;
            irq_mask = xs() & ~e;
            wait_pend(e);
            #2 irq_mask = e;
            wait_pend(32'h0);
        end
        #2 irq_mask = 32'h0;
        unit_irq = 8'hff;
        wait_pend(32'h000f_f000);
        #2 unit_irq = 8'h0;
        disp_irq = 1'b0;
        wait_pend(32'h0);
        `CHK("queue", 0, nq.size())
        results();
    end
endmodule
`default_nettype wire
